/* rtl/pll_cfg_params.svh */
// Purpose: constants for the serial configuration register bank
// Assumes: 32-bit words shifted in msb first, select code in the low bits
// Notes:   no reset values exist for the hardware; all words clear to zero
//
// Summary of operation
// - select codes 000, 001, 010 route the word into registers 0, 1, 2.
// - register 0 bits 30..15 hold the 16-bit integer division part.
// - register 0 bits 14..3 hold the 12-bit fraction numerator.
// - register 1 bit 27 picks the 4/5 or 8/9 prescaler ratio.
// - register 1 bits 26..15 hold the 12-bit phase word.
// - phase word sets output phase in steps of one turn over modulus.
// - register 1 bits 14..3 hold the 12-bit fractional modulus.
// - register 2 bits 30..29 choose low-noise or low-spur mode.
// - low-spur mode turns dithering on.
// - low-noise mode turns dithering off.
// - register 2 bits 28..26 pick the test output multiplexer source.
// - double-buffered fields take effect only at a later register 0 write.
// - divider select waits for register 0 only while reg 2 bit 13 high.
// - word is shifted msb first, one bit per rising serial clock edge.
// - load strobe rising edge copies the shift word into the selected latch.
// - select codes 011, 100, 101 route the word into registers 3, 4, 5.
`ifndef PLL_CFG_PARAMS_SVH
`define PLL_CFG_PARAMS_SVH

// ==========================================================================
// word layout
`define CFG_WORD_W        32
`define CFG_SEL_MSB       2
`define CFG_SEL_LSB       0
`define CFG_RESET_WORD    32'h0000_0000

// ==========================================================================
// register 0 / 1 fields
`define INT_MSB           30
`define INT_LSB           15
`define FRAC_MSB          14
`define FRAC_LSB          3
`define PRESC_BIT         27
`define PHASE_MSB         26
`define PHASE_LSB         15
`define MODULUS_MSB       14
`define MODULUS_LSB       3

// ==========================================================================
// register 2 / 4 fields
`define NOISE_MSB         30
`define NOISE_LSB         29
`define MUX_MSB           28
`define MUX_LSB           26
`define DOUBLER_BIT       25
`define RDIV2_BIT         24
`define RCOUNT_MSB        23
`define RCOUNT_LSB        14
`define DBUF_EN_BIT       13
`define CP_MSB            11
`define CP_LSB            9
`define DIVSEL_MSB        22
`define DIVSEL_LSB        20

`endif

/* rtl/pll_cfg_pkg.sv */
// Purpose: shared types of the serial configuration register bank
// Assumes: nothing beyond the params header
// Notes:   noise mode codes other than the two named ones keep dither off
package pll_cfg_pkg;

	typedef enum logic [2:0] {
		sel_int_frac     = 3'h0,
		sel_presc_phase  = 3'h1,
		sel_ref_mode     = 3'h2,
		sel_phase_resync = 3'h3,
		sel_output_stage = 3'h4,
		sel_pulse_pin    = 3'h5
	} reg_select_type;

	typedef enum logic [1:0] {
		noise_low_noise = 2'h0,
		noise_rsvd_a    = 2'h1,
		noise_rsvd_b    = 2'h2,
		noise_low_spur  = 2'h3
	} noise_mode_type;

endpackage : pll_cfg_pkg

/* rtl/pll_serial_config_registers.sv */
// Purpose: latch bank and active field registers of the synthesizer
// Assumes: host holds the serial clock still for 4 clk cycles after strobe
// Notes:   write-only bank; outputs are the fields the analog core uses
`timescale 1ns/1ps
`include "pll_cfg_params.svh"
module pll_serial_config_registers
	import pll_cfg_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic        sclk,
	input  wire logic        sdata,
	input  wire logic        load_strobe,
	output logic [15:0]      int_value,
	output logic [11:0]      frac_value,
	output logic             prescaler_select,
	output logic [11:0]      phase_word,
	output logic [11:0]      fraction_modulus,
	output noise_mode_type   noise_mode,
	output logic             dither_en,
	output logic [2:0]       test_output_mux,
	output logic             ref_doubler,
	output logic             ref_half,
	output logic [9:0]       ref_count,
	output logic [2:0]       cp_current,
	output logic [2:0]       divider_select,
	output logic [31:0]      phase_resync_word,
	output logic [31:0]      output_stage_word,
	output logic [31:0]      pulse_pin_word
);

	// ==================================================================
	// serial domain
	shift_word_if sw ();

	serial_shifter u_shifter (
		.sclk  (sclk),
		.nrst  (nrst),
		.sdata (sdata),
		.bus   (sw.shifter)
	);

	// ==================================================================
	// strobe crossing
	logic        strobe_meta_reg;
	logic        strobe_sync_reg;
	logic        strobe_prev_reg;
	logic        load_take;
	logic [31:0] latch_reg [6];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			strobe_meta_reg <= 1'b0;
			strobe_sync_reg <= 1'b0;
			strobe_prev_reg <= 1'b0;
		end else if (ce) begin
			strobe_meta_reg <= load_strobe;
			strobe_sync_reg <= strobe_meta_reg;
			strobe_prev_reg <= strobe_sync_reg;
		end
	end

	// word is sampled without its own synchroniser: it is frozen because
	// the serial clock stands still once the strobe has risen
	assign load_take = ce & strobe_sync_reg & ~strobe_prev_reg;

	function automatic logic targets(input logic [31:0] w,
					 input reg_select_type s);
		targets = (w[`CFG_SEL_MSB:`CFG_SEL_LSB] == s);
	endfunction : targets

	logic wr_r0;
	logic wr_r1;
	logic wr_r2;
	logic wr_r3;
	logic wr_r4;
	logic wr_r5;

	assign wr_r0 = load_take & targets(sw.word, sel_int_frac);
	assign wr_r1 = load_take & targets(sw.word, sel_presc_phase);
	assign wr_r2 = load_take & targets(sw.word, sel_ref_mode);
	assign wr_r3 = load_take & targets(sw.word, sel_phase_resync);
	assign wr_r4 = load_take & targets(sw.word, sel_output_stage);
	assign wr_r5 = load_take & targets(sw.word, sel_pulse_pin);

	// ==================================================================
	// latch bank
	// codes 110 and 111 match no latch and are dropped; no read path
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_latch
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					latch_reg[gi] <= `CFG_RESET_WORD;
				end else if (load_take &&
					     sw.word[2:0] == 3'(gi)) begin
					latch_reg[gi] <= sw.word;
				end
			end
		end
	endgenerate

	// ==================================================================
	// register 0 fields, immediate
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			int_value  <= 16'h0000;
			frac_value <= 12'h000;
		end else if (wr_r0) begin
			int_value  <= sw.word[`INT_MSB:`INT_LSB];
			frac_value <= sw.word[`FRAC_MSB:`FRAC_LSB];
		end
	end

	// ==================================================================
	// register 1 fields
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prescaler_select <= 1'b0;
		end else if (wr_r1) begin
			prescaler_select <= sw.word[`PRESC_BIT];
		end
	end

	// phase step is one turn over fraction_modulus in the core
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			phase_word       <= 12'h000;
			fraction_modulus <= 12'h000;
		end else if (wr_r0) begin
			phase_word       <= latch_reg[1][`PHASE_MSB:`PHASE_LSB];
			fraction_modulus <= latch_reg[1][`MODULUS_MSB:`MODULUS_LSB];
		end
	end

	// ==================================================================
	// register 2 fields
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			noise_mode      <= noise_low_noise;
			dither_en       <= 1'b0;
			test_output_mux <= 3'h0;
		end else if (wr_r2) begin
			noise_mode      <= noise_mode_type'(
				sw.word[`NOISE_MSB:`NOISE_LSB]);
			dither_en       <= (sw.word[`NOISE_MSB:`NOISE_LSB] ==
				noise_low_spur);
			test_output_mux <= sw.word[`MUX_MSB:`MUX_LSB];
		end
	end

	// reference path settings wait for the next register 0 write
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ref_doubler <= 1'b0;
			ref_half    <= 1'b0;
			ref_count   <= 10'h000;
			cp_current  <= 3'h0;
		end else if (wr_r0) begin
			ref_doubler <= latch_reg[2][`DOUBLER_BIT];
			ref_half    <= latch_reg[2][`RDIV2_BIT];
			ref_count   <= latch_reg[2][`RCOUNT_MSB:`RCOUNT_LSB];
			cp_current  <= latch_reg[2][`CP_MSB:`CP_LSB];
		end
	end

	// ==================================================================
	// register 4 divider select
	// buffering is judged by the stored bit 13 at each write; a pending
	// value left when bit 13 drops is applied by the next register 0 write
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			divider_select <= 3'h0;
		end else if (wr_r4 && !latch_reg[2][`DBUF_EN_BIT]) begin
			divider_select <= sw.word[`DIVSEL_MSB:`DIVSEL_LSB];
		end else if (wr_r0) begin
			divider_select <= latch_reg[4][`DIVSEL_MSB:`DIVSEL_LSB];
		end
	end

	// ==================================================================
	// registers 3, 4, 5 passed on whole
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			phase_resync_word <= `CFG_RESET_WORD;
			output_stage_word <= `CFG_RESET_WORD;
			pulse_pin_word    <= `CFG_RESET_WORD;
		end else begin
			if (wr_r3) begin
				phase_resync_word <= sw.word;
			end
			if (wr_r4) begin
				output_stage_word <= sw.word;
			end
			if (wr_r5) begin
				pulse_pin_word <= sw.word;
			end
		end
	end

	// ==================================================================
	// checks
	a_int_load: assert property (@(posedge clk) disable iff (!nrst)
		wr_r0 |=> int_value == $past(sw.word[30:15]))
		else $error("integer field not loaded from register 0");

	a_frac_load: assert property (@(posedge clk) disable iff (!nrst)
		wr_r0 |=> frac_value == $past(sw.word[14:3]))
		else $error("fraction field not loaded from register 0");

	a_presc_now: assert property (@(posedge clk) disable iff (!nrst)
		wr_r1 |=> prescaler_select == $past(sw.word[27]))
		else $error("prescaler select not applied at once");

	a_phase_held: assert property (@(posedge clk) disable iff (!nrst)
		wr_r1 |=> $stable(phase_word) && $stable(fraction_modulus))
		else $error("buffered field changed on register 1 write");

	a_phase_commit: assert property (@(posedge clk) disable iff (!nrst)
		wr_r0 |=> phase_word == $past(latch_reg[1][26:15]))
		else $error("phase word not committed by register 0");

	a_mod_commit: assert property (@(posedge clk) disable iff (!nrst)
		wr_r0 |=> fraction_modulus == $past(latch_reg[1][14:3]))
		else $error("modulus not committed by register 0");

	a_dither_mode: assert property (@(posedge clk) disable iff (!nrst)
		dither_en == (noise_mode == noise_low_spur))
		else $error("dither does not follow noise mode");

	a_mux_load: assert property (@(posedge clk) disable iff (!nrst)
		wr_r2 |=> test_output_mux == $past(sw.word[28:26]))
		else $error("multiplexer select not loaded");

	a_div_direct: assert property (@(posedge clk) disable iff (!nrst)
		wr_r4 && !latch_reg[2][13] |=>
		divider_select == $past(sw.word[22:20]))
		else $error("unbuffered divider select not applied");

	a_div_wait: assert property (@(posedge clk) disable iff (!nrst)
		wr_r4 && latch_reg[2][13] |=> $stable(divider_select))
		else $error("buffered divider select applied early");

	a_route_r5: assert property (@(posedge clk) disable iff (!nrst)
		wr_r5 |=> pulse_pin_word == $past(sw.word) &&
		$stable(int_value))
		else $error("register 5 word misrouted");

	a_no_load: assert property (@(posedge clk) disable iff (!nrst)
		!load_take |=> $stable(int_value) && $stable(noise_mode) &&
		$stable(pulse_pin_word))
		else $error("field changed without a strobe edge");

	a_noise_load: assert property (@(posedge clk) disable iff (!nrst)
		wr_r2 |=> noise_mode == $past(sw.word[30:29]))
		else $error("noise mode not loaded from register 2");

	a_spur_dith: assert property (@(posedge clk) disable iff (!nrst)
		wr_r2 && sw.word[30:29] == 2'h3 |=> dither_en)
		else $error("low spur mode left dithering off");

	a_quiet_dith: assert property (@(posedge clk) disable iff (!nrst)
		wr_r2 && sw.word[30:29] == 2'h0 |=> !dither_en)
		else $error("low noise mode left dithering on");

	// reference fields must ignore register 2 until the commit write
	a_ref_wait: assert property (@(posedge clk) disable iff (!nrst)
		wr_r2 |=> $stable(ref_doubler) && $stable(ref_half) &&
		$stable(ref_count) && $stable(cp_current))
		else $error("buffered reference field changed early");

	a_ref_apply: assert property (@(posedge clk) disable iff (!nrst)
		wr_r0 |=> ref_count == $past(latch_reg[2][23:14]) &&
		cp_current == $past(latch_reg[2][11:9]))
		else $error("reference fields not committed by register 0");

	a_route_r3: assert property (@(posedge clk) disable iff (!nrst)
		wr_r3 |=> phase_resync_word == $past(sw.word))
		else $error("register 3 word misrouted");

	a_route_r4: assert property (@(posedge clk) disable iff (!nrst)
		wr_r4 |=> output_stage_word == $past(sw.word))
		else $error("register 4 word misrouted");

	// codes 110 and 111 must leave int_value and the three whole-word outputs untouched
	a_bad_code: assert property (@(posedge clk) disable iff (!nrst)
		load_take && sw.word[2:1] == 2'h3 |=> $stable(int_value) &&
		$stable(phase_resync_word) && $stable(output_stage_word) &&
		$stable(pulse_pin_word))
		else $error("unused select code changed a field");

	a_ce_freeze: assert property (@(posedge clk) disable iff (!nrst)
		!ce |=> $stable(strobe_sync_reg) && $stable(int_value))
		else $error("state moved while clock enable low");

endmodule : pll_serial_config_registers

/* rtl/serial_shifter.sv */
// Purpose: 32-bit input shift register on the serial clock
// Assumes: serial clock runs only while the host shifts a word
// Notes:   no bit counter; extra bits simply push out the oldest ones
`timescale 1ns/1ps
`include "pll_cfg_params.svh"
module serial_shifter (
	input  wire logic          sclk,
	input  wire logic          nrst,
	input  wire logic          sdata,
	shift_word_if.shifter      bus
);
	logic [31:0] shift_reg;

	// ==================================================================
	// shift path
	always_ff @(posedge sclk or negedge nrst) begin
		if (!nrst) begin
			shift_reg <= `CFG_RESET_WORD;
		end else begin
			shift_reg <= {shift_reg[30:0], sdata};
		end
	end

	assign bus.word = shift_reg;

endmodule : serial_shifter

/* rtl/shift_word_if.sv */
// Purpose: carries the shifted word from the serial clock domain
// Assumes: word is quasi-static once the serial clock stops
// Notes:   consumer samples only after a synchronised strobe edge
`timescale 1ns/1ps
interface shift_word_if;
	logic [31:0] word;

	modport shifter (output word);
	modport latcher (input word);
endinterface : shift_word_if

/* testbench/serial_host.sv */
// Purpose: host model driving the three-wire serial port
// Assumes: serial clock period 64 ns, unrelated to the system clock
// Notes:   serial clock stands still between frames
`timescale 1ns/1ps
module serial_host (
	output logic sclk,
	output logic sdata,
	output logic load_strobe
);
	initial begin
		sclk        = 1'b0;
		sdata       = 1'b0;
		load_strobe = 1'b0;
	end

	// ==========================================================================
	// one frame: 32 bits then strobe
	// caller passes words with reserved bits at their fixed values
	task automatic write_word(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			sdata <= w[i];
			#32 sclk <= 1'b1;
			#32 sclk <= 1'b0;
		end
		// data line no longer valid, so do not leave the last bit on it
		sdata <= ~w[0];
		#32 load_strobe <= 1'b1;
		// clock stays quiet well past the crossing window
		#300 load_strobe <= 1'b0;
		#200;
	endtask : write_word
endmodule : serial_host

/* testbench/testbench.sv */
// Purpose: self-checking bench for the serial configuration register bank
// Assumes: ce held high except in the clock enable test; host model owns the serial pins
// Notes:   expectations built from the field layout of each word
`timescale 1ns/1ps
module testbench;
	import pll_cfg_pkg::*;
	logic           clk, nrst, ce, sclk, sdata, load_strobe;
	logic [15:0]    int_value;
	logic [11:0]    frac_value, phase_word, fraction_modulus;
	logic           prescaler_select, dither_en, ref_doubler, ref_half;
	noise_mode_type noise_mode;
	logic [2:0]     test_output_mux, cp_current, divider_select;
	logic [9:0]     ref_count;
	logic [31:0]    phase_resync_word, output_stage_word, pulse_pin_word;
	int             num_errors, comparisons;

	localparam logic [31:0] W0A = {1'b0, 16'h004b,
		12'h005, 3'h0};
	localparam logic [31:0] W0B = {1'b0, 16'h0050, 12'h003, 3'h0};
	localparam logic [31:0] W1 = {4'h0, 1'b1,
		12'h001,
		12'h00a, 3'h1};
	// lock detect code of the multiplexer is not fixed here; value assumed
	localparam logic [2:0]  MUX_DIG_LOCK = 3'h1;
	localparam logic [31:0] W2S = {1'b0, 2'h3, 3'h6, 2'h2, 10'h005,
		1'b1, 1'b0, 3'h7, 6'h08, 3'h2};
	localparam logic [31:0] W2N = {1'b0, 2'h0, MUX_DIG_LOCK, 2'h0,
		10'h001, 1'b0, 1'b0, 3'h1, 6'h08, 3'h2};
	localparam logic [31:0] W4A = {8'h00, 1'b1, 3'h5, 9'h000, 1'b1,
		4'h0, 1'b1, 2'h3, 3'h4};
	localparam logic [31:0] W4B = {8'h00, 1'b0, 3'h2, 9'h000, 1'b0,
		4'h0, 1'b1, 2'h1, 3'h4};
	localparam logic [31:0] W3 = {13'h0000, 1'b1, 1'b0, 2'h2, 12'h0ff, 3'h3};
	localparam logic [31:0] W5 = {2'h0, 1'b1, 1'b1, 4'h0, 2'h1, 19'h0, 3'h5};
	localparam logic [31:0] W5B = {2'h0, 1'b1, 1'b1, 4'h0, 2'h3, 19'h0, 3'h5};

	pll_serial_config_registers dut_u (.clk(clk), .nrst(nrst), .ce(ce),
		.sclk(sclk), .sdata(sdata), .load_strobe(load_strobe),
		.int_value(int_value), .frac_value(frac_value),
		.prescaler_select(prescaler_select), .phase_word(phase_word),
		.fraction_modulus(fraction_modulus), .noise_mode(noise_mode),
		.dither_en(dither_en), .test_output_mux(test_output_mux),
		.ref_doubler(ref_doubler), .ref_half(ref_half),
		.ref_count(ref_count), .cp_current(cp_current),
		.divider_select(divider_select),
		.phase_resync_word(phase_resync_word),
		.output_stage_word(output_stage_word),
		.pulse_pin_word(pulse_pin_word));

	serial_host host_u (.sclk(sclk), .sdata(sdata),
		.load_strobe(load_strobe));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ==========================================================================
	// shared helpers
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// host frame lasts past the latest update edge, so outputs are settled
	task send(input logic [31:0] w);
		host_u.write_word(w);
		@(posedge clk);
	endtask : send

	task test_done;
		$display("errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done

	// ==========================================================================
	// scenarios
	task test_buffered;
		send(W1);
		chk(prescaler_select, 1);
		chk(phase_word, 0);
		chk(fraction_modulus, 0);
		send(W0A);
		chk(int_value, 16'h004b);
		chk(frac_value, 12'h005);
		chk(phase_word, 12'h001);
		chk(fraction_modulus, 12'h00a);
		$display("test buffered done");
	endtask : test_buffered

	task test_spur_mode;
		send(W2S);
		chk(noise_mode, 2'h3);
		chk(dither_en, 1);
		chk(test_output_mux, 3'h6);
		chk({ref_doubler, ref_count, cp_current}, 0);
		send(W4A);
		chk(output_stage_word, W4A);
		chk(divider_select, 0);
		send(W0B);
		chk(int_value, 16'h0050);
		chk({ref_doubler, ref_half}, 2'h2);
		chk({ref_count, cp_current}, {10'h005, 3'h7});
		chk(divider_select, 3'h5);
		$display("test spur mode done");
	endtask : test_spur_mode

	task test_noise_mode;
		send(W2N);
		chk(noise_mode, 2'h0);
		chk(dither_en, 0);
		chk(test_output_mux, 3'h1);
		chk(ref_count, 10'h005);
		send(W4B);
		chk(divider_select, 3'h2);
		send(W3);
		chk(phase_resync_word, W3);
		send(W5);
		chk(pulse_pin_word, W5);
		$display("test noise mode done");
	endtask : test_noise_mode

	task test_bad_select;
		send({29'h1fff_ffff, 3'h6});
		send({29'h1fff_ffff, 3'h7});
		chk(int_value, 16'h0050);
		chk(phase_resync_word, W3);
		chk(output_stage_word, W4B);
		chk(pulse_pin_word, W5);
		$display("test bad select done");
	endtask : test_bad_select

	// strobe seen only while ce is high; a frozen edge detector drops it
	task test_clock_enable;
		@(posedge clk);
		ce <= 1'b0;
		send(W5B);
		chk(pulse_pin_word, W5);
		@(posedge clk);
		ce <= 1'b1;
		send(W5B);
		chk(pulse_pin_word, W5B);
		chk(int_value, 16'h0050);
		$display("test clock enable done");
	endtask : test_clock_enable

	// ==========================================================================
	// main sequence and watchdog
	initial begin
		num_errors = 0;
		comparisons = 0;
		nrst = 1'b0;
		ce = 1'b1;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		test_buffered;
		test_spur_mode;
		test_noise_mode;
		test_bad_select;
		test_clock_enable;
		test_done;
	end

	initial begin
		#200000;
		num_errors++;
		test_done;
	end
endmodule : testbench
